// [core/odc_pkg.sv]
// Constants, field layouts and decode helpers for the output driver config bank
package odc_pkg;

  localparam int NUM_CLK  = 8;
  localparam int NUM_SREF = 7;
  localparam int MV_W     = 11;
  localparam int PS_W     = 12;

  // Clock output config offsets, order A0 A1 B0 B1 C D E0 E1
  localparam logic [7:0] OFS_CLK_CFG [NUM_CLK] = '{
    8'h24, 8'h25, 8'h34, 8'h35, 8'h45, 8'h54, 8'h64, 8'h65};
  // SYSREF offsets, order A0 A1 A2 B0 B1 C D
  localparam logic [7:0] OFS_SREF_DLY [NUM_SREF] = '{
    8'h28, 8'h29, 8'h2A, 8'h38, 8'h39, 8'h49, 8'h58};
  localparam logic [7:0] OFS_SREF_DRV [NUM_SREF] = '{
    8'h2C, 8'h2D, 8'h2E, 8'h3C, 8'h3D, 8'h4C, 8'h5C};
  localparam logic [7:0] OFS_CLK_EN_LO = 8'h74;
  localparam logic [7:0] OFS_CLK_EN_HI = 8'h75;
  localparam logic [7:0] OFS_SREF_EN   = 8'h76;

  // Driver config byte layout (clock and SYSREF share it)
  localparam int DRV_PD_BIT    = 7;
  localparam int DRV_BIAS_BIT  = 5;
  localparam int DRV_STYLE_BIT = 4;
  localparam int DRV_AMP_LSB   = 2;
  localparam logic [7:0] CLK_CFG_MASK  = 8'h9C;
  localparam logic [7:0] SREF_DRV_MASK = 8'hBC;

  // Delay / source byte layout
  localparam int DLY_FINE_LO_LSB = 5;
  localparam int DLY_MUX_BIT     = 4;
  localparam int DLY_COARSE_LSB  = 1;
  localparam int DLY_FINE_HI_BIT = 0;
  localparam logic [7:0] SREF_DLY_MASK = 8'h7F;

  // Enable bytes; bit index into {byte 0x75, byte 0x74} per clock output
  localparam logic [7:0] CLK_EN_LO_MASK = 8'hDB;
  localparam logic [7:0] CLK_EN_HI_MASK = 8'h03;
  localparam logic [3:0] CLK_EN_POS [NUM_CLK] = '{
    4'h7, 4'h6, 4'h4, 4'h3, 4'h1, 4'h0, 4'h8, 4'h9};
  localparam logic [2:0] SREF_EN_POS [NUM_SREF] = '{
    3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h0};
  localparam logic [7:0] SREF_EN_MASK = 8'hFF;

  // Reset values
  localparam logic [7:0] RST_CLK_CFG  = 8'h00;
  localparam logic [7:0] RST_SREF_DLY = 8'h10;
  localparam logic [7:0] RST_SREF_DRV = 8'h00;
  localparam logic [7:0] RST_EN       = 8'h00;

  // Analog figures
  localparam int SWING_STEP_MV  = 250;
  localparam int COARSE_STEP_PS = 255;
  localparam logic [PS_W-1:0] FINE_PS [8] = '{
    12'h000, 12'h019, 12'h032, 12'h04B,
    12'h055, 12'h06E, 12'h087, 12'h0A0};

  // Swing code to millivolts, same table for both formats
  function automatic logic [MV_W-1:0] swing_mv(input logic [1:0] code);
    swing_mv = MV_W'((int'(code) + 1) * SWING_STEP_MV);
  endfunction

endpackage

// [core/odc_sref_if.sv]
// Carrier between the register bank and one SYSREF output decoder
`timescale 1ns/1ns
`default_nettype none
interface odc_sref_if;
  import odc_pkg::*;
  logic [7:0]      dly_reg;
  logic [7:0]      drv_reg;
  logic            enable;
  logic            bias_sel;
  logic            source_sel;
  logic [PS_W-1:0] delay_ps;
  logic [MV_W-1:0] swing_mv_out;
  logic            format;
  logic            bias_on;
  logic            powerdown;
  logic            drive_on;

  modport regs (
    output dly_reg, drv_reg, enable, bias_sel,
    input  source_sel, delay_ps, swing_mv_out, format, bias_on,
    input  powerdown, drive_on
  );
  modport dec (
    input  dly_reg, drv_reg, enable, bias_sel,
    output source_sel, delay_ps, swing_mv_out, format, bias_on,
    output powerdown, drive_on
  );
endinterface
`default_nettype wire

// [core/odc_sref_decode.sv]
// Decoder from raw SYSREF register bytes to registered driver settings
`timescale 1ns/1ns
`default_nettype none
module odc_sref_decode (
  input wire logic clk,
  input wire logic rst_n,
  odc_sref_if.dec  sr
);
  import odc_pkg::*;

  logic [2:0]      coarse;
  logic [2:0]      fine;
  logic [PS_W-1:0] next_delay;

  // Fine code is split: two bits high in the byte, one at bit 0
  always_comb begin
    coarse = sr.dly_reg[DLY_COARSE_LSB +: 3];
    fine   = {sr.dly_reg[DLY_FINE_HI_BIT],
              sr.dly_reg[DLY_FINE_LO_LSB +: 2]};
    next_delay = PS_W'(int'(coarse) * COARSE_STEP_PS)
               + FINE_PS[fine];
  end

  // Registered outputs so the analog side sees glitch-free settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr.source_sel   <= RST_SREF_DLY[DLY_MUX_BIT];
      sr.delay_ps     <= '0;
      sr.swing_mv_out <= swing_mv(RST_SREF_DRV[DRV_AMP_LSB +: 2]);
      sr.format       <= 1'b0;
      sr.bias_on      <= 1'b0;
      sr.powerdown    <= 1'b0;
      sr.drive_on     <= 1'b0;
    end else begin
      sr.source_sel   <= sr.dly_reg[DLY_MUX_BIT];
      sr.delay_ps     <= next_delay;
      sr.swing_mv_out <= swing_mv(sr.drv_reg[DRV_AMP_LSB +: 2]);
      sr.format       <= sr.drv_reg[DRV_STYLE_BIT];
      // Bias bit has no effect unless the global scheme selects it
      sr.bias_on      <= sr.bias_sel & sr.drv_reg[DRV_BIAS_BIT];
      sr.powerdown    <= sr.drv_reg[DRV_PD_BIT];
      sr.drive_on     <= sr.enable;
    end
  end
endmodule
`default_nettype wire

// [core/odc_output_driver_config_regs.sv]
// Output driver configuration register bank for clock and SYSREF outputs
//
// Overview of operation
// - Differential swing codes 00..11 give 250/500/750/1000 mV, reset 00.
// - Emitter-coupled format uses the same four swing amplitudes.
// - Format bit 0 (reset) is low-voltage differential, 1 emitter-coupled.
// - Enable bit 0 (reset) parks a clock output low, 1 lets it toggle.
// - Source select 0 routes channel clock, 1 (reset) central SYSREF.
// - Register contents set format, swing, power state and output states.
// - Power-down bit 0 (reset) powers a clock output up, 1 powers it down.
// - SYSREF coarse delay is the 3-bit code times 255 ps, code 000 none.
// - Fine codes 000..011 add 0, 25, 50, 75 ps on top of the coarse delay.
// - SYSREF bias bit takes effect only when the global scheme select is 1.
`timescale 1ns/1ns
`default_nettype none
module odc_output_driver_config_regs (
  input  wire logic                                         REF_CLK,
  input  wire logic                                         RESET_N,
  input  wire logic [7:0]                                   REG_ADDR,
  input  wire logic [7:0]                                   REG_WDATA,
  input  wire logic                                         REG_WR,
  input  wire logic                                         REG_RD,
  output logic      [7:0]                                   REG_RDATA,
  input  wire logic                                         BIAS_SCHEME_SEL,
  output logic      [odc_pkg::NUM_CLK-1:0][odc_pkg::MV_W-1:0]  CLK_SWING_MV,
  output logic      [odc_pkg::NUM_CLK-1:0]                  CLK_FORMAT,
  output logic      [odc_pkg::NUM_CLK-1:0]                  CLK_DRIVE_ON,
  output logic      [odc_pkg::NUM_CLK-1:0]                  CLK_POWERDOWN,
  output logic      [odc_pkg::NUM_SREF-1:0]                 SREF_SOURCE_SEL,
  output logic      [odc_pkg::NUM_SREF-1:0][odc_pkg::PS_W-1:0] SREF_DELAY_PS,
  output logic      [odc_pkg::NUM_SREF-1:0][odc_pkg::MV_W-1:0] SREF_SWING_MV,
  output logic      [odc_pkg::NUM_SREF-1:0]                 SREF_FORMAT,
  output logic      [odc_pkg::NUM_SREF-1:0]                 SREF_BIAS_ON,
  output logic      [odc_pkg::NUM_SREF-1:0]                 SREF_POWERDOWN,
  output logic      [odc_pkg::NUM_SREF-1:0]                 SREF_DRIVE_ON
);
  import odc_pkg::*;

  logic       rst_meta;
  logic       rst_n;
  logic [7:0] clk_cfg  [NUM_CLK];
  logic [7:0] sref_dly [NUM_SREF];
  logic [7:0] sref_drv [NUM_SREF];
  logic [7:0] clk_en_lo;
  logic [7:0] clk_en_hi;
  logic [7:0] sref_en;
  logic [15:0] clk_en_all;
  logic [7:0] next_rdata;

  // Reset release synchroniser; assertion stays asynchronous
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Clock output config bytes, reserved bits masked on write
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CLK; gc++) begin : g_clk_cfg
      always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
          clk_cfg[gc] <= RST_CLK_CFG;
        end else if (REG_WR && REG_ADDR == OFS_CLK_CFG[gc]) begin
          clk_cfg[gc] <= REG_WDATA & CLK_CFG_MASK;
        end
      end
    end
  endgenerate

  // SYSREF delay/source and driver bytes
  genvar gs;
  generate
    for (gs = 0; gs < NUM_SREF; gs++) begin : g_sref_cfg
      always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
          sref_dly[gs] <= RST_SREF_DLY;
        end else if (REG_WR && REG_ADDR == OFS_SREF_DLY[gs]) begin
          sref_dly[gs] <= REG_WDATA & SREF_DLY_MASK;
        end
      end
      always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
          sref_drv[gs] <= RST_SREF_DRV;
        end else if (REG_WR && REG_ADDR == OFS_SREF_DRV[gs]) begin
          sref_drv[gs] <= REG_WDATA & SREF_DRV_MASK;
        end
      end
    end
  endgenerate

  // Enable bytes shared by several outputs
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      clk_en_lo <= RST_EN;
      clk_en_hi <= RST_EN;
      sref_en   <= RST_EN;
    end else if (REG_WR) begin
      if (REG_ADDR == OFS_CLK_EN_LO) begin
        clk_en_lo <= REG_WDATA & CLK_EN_LO_MASK;
      end
      if (REG_ADDR == OFS_CLK_EN_HI) begin
        clk_en_hi <= REG_WDATA & CLK_EN_HI_MASK;
      end
      if (REG_ADDR == OFS_SREF_EN) begin
        sref_en <= REG_WDATA & SREF_EN_MASK;
      end
    end
  end

  assign clk_en_all = {clk_en_hi, clk_en_lo};

  // Readback mux; unmapped and reserved positions read as zero, except unused bit 1 of the SYSREF enable byte
  always_comb begin
    next_rdata = 8'h00;
    for (int i = 0; i < NUM_CLK; i++) begin
      if (REG_ADDR == OFS_CLK_CFG[i]) begin
        next_rdata = clk_cfg[i];
      end
    end
    for (int i = 0; i < NUM_SREF; i++) begin
      if (REG_ADDR == OFS_SREF_DLY[i]) begin
        next_rdata = sref_dly[i];
      end
      if (REG_ADDR == OFS_SREF_DRV[i]) begin
        next_rdata = sref_drv[i];
      end
    end
    if (REG_ADDR == OFS_CLK_EN_LO) begin
      next_rdata = clk_en_lo;
    end
    if (REG_ADDR == OFS_CLK_EN_HI) begin
      next_rdata = clk_en_hi;
    end
    if (REG_ADDR == OFS_SREF_EN) begin
      next_rdata = sref_en;
    end
  end

  // Read data held until the next read so slow serial logic can shift it
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end
  end

  // Clock output decode, one stage of flops toward the drivers
  genvar gd;
  generate
    for (gd = 0; gd < NUM_CLK; gd++) begin : g_clk_dec
      always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
          CLK_SWING_MV[gd]  <= swing_mv(RST_CLK_CFG[DRV_AMP_LSB +: 2]);
          CLK_FORMAT[gd]    <= 1'b0;
          CLK_DRIVE_ON[gd]  <= 1'b0;
          CLK_POWERDOWN[gd] <= 1'b0;
        end else begin
          // Same table whichever format is chosen
          CLK_SWING_MV[gd]  <=
            swing_mv(clk_cfg[gd][DRV_AMP_LSB +: 2]);
          CLK_FORMAT[gd]    <= clk_cfg[gd][DRV_STYLE_BIT];
          // Low means the output stage parks at static logic low
          CLK_DRIVE_ON[gd]  <= clk_en_all[CLK_EN_POS[gd]];
          CLK_POWERDOWN[gd] <= clk_cfg[gd][DRV_PD_BIT];
        end
      end
    end
  endgenerate

  // SYSREF decoders, each fed through its own carrier
  genvar gr;
  generate
    for (gr = 0; gr < NUM_SREF; gr++) begin : g_sref_dec
      odc_sref_if sr_if ();

      assign sr_if.dly_reg  = sref_dly[gr];
      assign sr_if.drv_reg  = sref_drv[gr];
      assign sr_if.enable   = sref_en[SREF_EN_POS[gr]];
      assign sr_if.bias_sel = BIAS_SCHEME_SEL;

      odc_sref_decode u_dec (
        .clk   (REF_CLK),
        .rst_n (rst_n),
        .sr    (sr_if.dec)
      );

      assign SREF_SOURCE_SEL[gr] = sr_if.source_sel;
      assign SREF_DELAY_PS[gr]   = sr_if.delay_ps;
      assign SREF_SWING_MV[gr]   = sr_if.swing_mv_out;
      assign SREF_FORMAT[gr]     = sr_if.format;
      assign SREF_BIAS_ON[gr]    = sr_if.bias_on;
      assign SREF_POWERDOWN[gr]  = sr_if.powerdown;
      assign SREF_DRIVE_ON[gr]   = sr_if.drive_on;
    end
  endgenerate

endmodule
`default_nettype wire

// [sim/odc_regs_asserts.sv]
// Port-level assertions for the output driver config register bank
`timescale 1ns/1ns
`default_nettype none
module odc_regs_asserts (
  input wire logic                                            REF_CLK,
  input wire logic                                            RESET_N,
  input wire logic [7:0]                                      REG_ADDR,
  input wire logic [7:0]                                      REG_WDATA,
  input wire logic                                            REG_WR,
  input wire logic                                            REG_RD,
  input wire logic [7:0]                                      REG_RDATA,
  input wire logic                                            BIAS_SCHEME_SEL,
  input wire logic [odc_pkg::NUM_CLK-1:0][odc_pkg::MV_W-1:0]  CLK_SWING_MV,
  input wire logic [odc_pkg::NUM_CLK-1:0]                     CLK_FORMAT,
  input wire logic [odc_pkg::NUM_CLK-1:0]                     CLK_DRIVE_ON,
  input wire logic [odc_pkg::NUM_CLK-1:0]                     CLK_POWERDOWN,
  input wire logic [odc_pkg::NUM_SREF-1:0]                    SREF_SOURCE_SEL,
  input wire logic [odc_pkg::NUM_SREF-1:0][odc_pkg::PS_W-1:0] SREF_DELAY_PS,
  input wire logic [odc_pkg::NUM_SREF-1:0]                    SREF_BIAS_ON
);
  import odc_pkg::*;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);

  // A write taken at one address; a read with no read right behind it
  sequence s_wr(logic [7:0] a);
    REG_WR && REG_ADDR == a;
  endsequence
  sequence s_rd_alone(logic [7:0] a);
    REG_RD && REG_ADDR == a ##1 !REG_RD;
  endsequence

  // Decoded fields follow the written byte two edges later
  a_clk_swing: assert property (
    s_wr(8'h24) |-> ##2
    CLK_SWING_MV[0] == 11'h0FA * ($past(REG_WDATA[3:2], 2) + 11'h001))
    else $error("clock swing decode wrong");
  a_clk_format: assert property (
    s_wr(8'h24) |-> ##2 CLK_FORMAT[0] == $past(REG_WDATA[4], 2))
    else $error("clock format decode wrong");
  a_clk_pdown: assert property (
    s_wr(8'h35) |-> ##2 CLK_POWERDOWN[3] == $past(REG_WDATA[7], 2))
    else $error("clock power-down decode wrong");
  a_clk_enable: assert property (
    s_wr(8'h74) |-> ##2 CLK_DRIVE_ON[0] == $past(REG_WDATA[7], 2))
    else $error("clock enable decode wrong");
  a_sref_source: assert property (
    s_wr(8'h28) |-> ##2 SREF_SOURCE_SEL[0] == $past(REG_WDATA[4], 2))
    else $error("sync source select wrong");
  a_sref_delay: assert property (
    s_wr(8'h28) ##0 !REG_WDATA[0] |-> ##2
    SREF_DELAY_PS[0] == 12'h0FF * $past(REG_WDATA[3:1], 2)
    + 12'h019 * $past(REG_WDATA[6:5], 2))
    else $error("sync delay decode wrong");
  // Bias pin has a short pipeline, so wait three quiet samples
  a_bias_gate: assert property (
    !BIAS_SCHEME_SEL [*3] |-> SREF_BIAS_ON == 7'h00)
    else $error("bias applied with scheme select low");
  a_rsvd_zero: assert property (
    s_rd_alone(8'h24) |-> ##1 (REG_RDATA & 8'h63) == 8'h00)
    else $error("reserved bits read nonzero");
  a_unmapped_rd: assert property (
    s_rd_alone(8'h00) |-> ##1 REG_RDATA == 8'h00)
    else $error("unmapped read nonzero");
endmodule

bind odc_output_driver_config_regs odc_regs_asserts u_odc_regs_asserts (.*);
`default_nettype wire

// [sim/odc_output_driver_config_regs_tb_top.sv]
// Self-checking bench for the output driver config register bank
`timescale 1ns/1ns
`default_nettype none
module odc_output_driver_config_regs_tb_top;
  import odc_pkg::*;
  logic                          clk = 1'b0;
  logic                          rst_n = 1'b0;
  logic [7:0]                    addr = 8'h00;
  logic [7:0]                    wdata = 8'h00;
  logic                          wr = 1'b0;
  logic                          rd = 1'b0;
  logic                          bsel = 1'b0;
  logic [7:0]                    rdata;
  logic [NUM_CLK-1:0][MV_W-1:0]  c_mv;
  logic [NUM_CLK-1:0]            c_fmt, c_on, c_pd;
  logic [NUM_SREF-1:0]           s_src, s_fmt, s_bias, s_pd, s_on;
  logic [NUM_SREF-1:0][PS_W-1:0] s_ps;
  logic [NUM_SREF-1:0][MV_W-1:0] s_mv;
  int                            errors = 0;
  int                            cmp_count = 0;

  // 20 MHz reference clock
  always #25 clk = ~clk;

  odc_output_driver_config_regs u_odc_output_driver_config_regs (
    .REF_CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .BIAS_SCHEME_SEL(bsel),
    .CLK_SWING_MV(c_mv), .CLK_FORMAT(c_fmt), .CLK_DRIVE_ON(c_on),
    .CLK_POWERDOWN(c_pd), .SREF_SOURCE_SEL(s_src), .SREF_DELAY_PS(s_ps),
    .SREF_SWING_MV(s_mv), .SREF_FORMAT(s_fmt), .SREF_BIAS_ON(s_bias),
    .SREF_POWERDOWN(s_pd), .SREF_DRIVE_ON(s_on));

  task automatic end_sim;
    $display("Compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Strobes move on the falling edge, one-cycle pulse each
  task automatic wr_reg(input logic [7:0] a, d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // Two spare edges past the decode flops; the bias pin settles on the first edge as well
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask

  task automatic t_reset;
    logic [7:0] v;
    for (int i = 0; i < NUM_CLK; i++) begin
      rd_reg(OFS_CLK_CFG[i], v);
      chk("clk_cfg_rst", 16'(v), 16'h0000);
      chk("clk_mv_rst", 16'(c_mv[i]), 16'h00FA);
      chk("clk_on_rst", 16'(c_on[i]), 16'h0000);
    end
    for (int i = 0; i < NUM_SREF; i++) begin
      rd_reg(OFS_SREF_DLY[i], v);
      chk("sref_dly_rst", 16'(v), 16'h0010);
      chk("sref_src_rst", 16'(s_src[i]), 16'h0001);
      chk("sref_ps_rst", 16'(s_ps[i]), 16'h0000);
    end
  endtask

  // All swing codes in both formats, reserved bits written as ones
  task automatic t_clk_cfg;
    logic [7:0] d;
    logic [7:0] v;
    for (int i = 0; i < NUM_CLK; i++) begin
      for (int k = 0; k < 8; k++) begin
        d = {k[0] ^ k[1], 2'b11, k[2], k[1:0], 2'b11};
        wr_reg(OFS_CLK_CFG[i], d);
        settle();
        chk("clk_mv", 16'(c_mv[i]), 16'h00FA * (k[1:0] + 16'h0001));
        chk("clk_fmt", 16'(c_fmt[i]), 16'(k[2]));
        chk("clk_pd", 16'(c_pd[i]), 16'(k[0] ^ k[1]));
        rd_reg(OFS_CLK_CFG[i], v);
        chk("clk_cfg_rd", 16'(v), 16'(d & 8'h9C));
      end
    end
  endtask

  // Walk one enable bit per output across all three enable bytes
  task automatic t_enables;
    logic [15:0] e;
    logic [7:0]  v;
    for (int i = 0; i < NUM_CLK; i++) begin
      e = 16'h0001 << CLK_EN_POS[i];
      wr_reg(OFS_CLK_EN_LO, e[7:0]);
      wr_reg(OFS_CLK_EN_HI, e[15:8]);
      settle();
      chk("clk_on", 16'(c_on), 16'h0001 << i);
    end
    for (int i = 0; i < NUM_SREF; i++) begin
      wr_reg(OFS_SREF_EN, 8'h01 << SREF_EN_POS[i]);
      settle();
      chk("sref_on", 16'(s_on), 16'h0001 << i);
    end
    wr_reg(OFS_CLK_EN_HI, 8'hFF);
    rd_reg(OFS_CLK_EN_HI, v);
    chk("clk_en_hi_rd", 16'(v), 16'h0003);
  endtask

  // Source, coarse and fine delay, driver fields and bias gating
  task automatic t_sref;
    logic [7:0]  d;
    logic [7:0]  g;
    logic [7:0]  v;
    logic [15:0] f;
    for (int i = 0; i < NUM_SREF; i++) begin
      for (int k = 0; k < 8; k++) begin
        d = {1'b1, k[1:0], k[0], k[2:0], k[2]};
        g = {k[1], 1'b1, k[1], k[2], k[1:0], 2'b11};
        f = (k < 4) ? 16'h0019 * 16'(k) : 16'(FINE_PS[k]);
        wr_reg(OFS_SREF_DLY[i], d);
        wr_reg(OFS_SREF_DRV[i], g);
        bsel = k[0];
        settle();
        chk("sref_src", 16'(s_src[i]), 16'(k[0]));
        chk("sref_ps", 16'(s_ps[i]), 16'h00FF * 16'(k) + f);
        chk("sref_mv", 16'(s_mv[i]), 16'h00FA * (k[1:0] + 16'h0001));
        chk("sref_fmt", 16'(s_fmt[i]), 16'(k[2]));
        chk("sref_pd", 16'(s_pd[i]), 16'(k[1]));
        chk("sref_bias", 16'(s_bias[i]), 16'(k[0] & k[1]));
        rd_reg(OFS_SREF_DRV[i], v);
        chk("sref_drv_rd", 16'(v), 16'(g & 8'hBC));
      end
    end
  endtask

  // Unmapped places take writes silently and read as zero
  task automatic t_unmapped;
    logic [7:0] v;
    wr_reg(8'h00, 8'hFF);
    wr_reg(8'h26, 8'hFF);
    rd_reg(8'h00, v);
    chk("unmapped_00", 16'(v), 16'h0000);
    rd_reg(8'h26, v);
    chk("unmapped_26", 16'(v), 16'h0000);
  endtask

  // Reset for eight cycles, then give the release synchroniser time
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_clk_cfg();
    t_enables();
    t_sref();
    t_unmapped();
    end_sim();
  end

  // Scenarios need about 1230 cycles; the bound is kept well above that
  initial begin
    #(50 * 20000);
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
